/* File: logic/css_sequencer.v */
// Clock switch sequencer: keyed control register, switch state machine, source gating
//
// The strobed register port and the register addresses were chosen for this implementation.
`include "css_consts.vh"

module css_sequencer (
    // Clock and reset
    input  wire        ref_clk,
    input  wire        rstn,
    // Register port
    input  wire [3:0]  addr,
    input  wire [7:0]  wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    // Configuration
    input  wire [1:0]  switch_config_bits,
    input  wire [2:0]  startup_source,
    input  wire        secondary_pin_select,
    input  wire        secondary_ext_mode,
    input  wire        watchdog_en,
    input  wire        fail_safe_monitor_en,
    // Secondary oscillator users
    input  wire        sec_user_req,
    // Oscillator status pins
    input  wire [5:0]  osc_ready,
    input  wire        pll_locked,
    input  wire        startup_timer_done,
    input  wire [5:0]  osc_clk,
    input  wire        ext_low_freq_clk_pin,
    // Oscillator controls
    output reg  [5:0]  osc_enable,
    output wire        sec_driver_en,
    output wire        sec_pins_digital,
    output wire        sec_user_clk,
    output reg  [2:0]  sys_clk_sel,
    output wire        switch_busy,
    output wire        core_stall
);
    localparam ST_IDLE   = 3'd0;
    localparam ST_CHECK  = 3'd1;
    localparam ST_WAIT   = 3'd2;
    localparam ST_SETTLE = 3'd3;
    localparam ST_SWAP   = 3'd4;
    localparam ST_HANDOFF = 3'd5;

    reg  [2:0] state;
    reg  [2:0] cur_src;
    reg  [2:0] req_src;
    reg        swreq;
    reg        lock_flag;
    reg        fail_flag;
    reg        force_on;
    reg  [1:0] hi_key;
    reg  [1:0] lo_key;
    reg  [3:0] settle_cnt;
    reg  [2:0] old_src;
    reg        cur_valid;
    wire       sw_enable = (switch_config_bits == 2'b00);

    // Synchronised oscillator status and the selected new clock
    wire [5:0] ready_s;
    wire       lock_s;
    wire       ost_s;
    wire       new_clk_s;
    wire       ext_clk_s;
    css_sync #(.WIDTH(10)) u_sync (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .din     ({osc_ready, pll_locked, startup_timer_done,
                   osc_clk[req_src], ext_low_freq_clk_pin}),
        .dout    ({ready_s, lock_s, ost_s, new_clk_s, ext_clk_s})
    );
    reg        new_clk_d;
    wire       new_clk_rise = new_clk_s & ~new_clk_d;

    wire is_pll_req  = (req_src == `CSS_SRC_FAST_RC_WITH_PLL) || (req_src == `CSS_SRC_PRIPLL);
    wire is_xtal_req = (req_src == `CSS_SRC_PRI) || (req_src == `CSS_SRC_PRIPLL) ||
                       (req_src == `CSS_SRC_SEC);
    wire pll_cross   = (cur_src == `CSS_SRC_PRIPLL && req_src == `CSS_SRC_FAST_RC_WITH_PLL) ||
                       (cur_src == `CSS_SRC_FAST_RC_WITH_PLL && req_src == `CSS_SRC_PRIPLL);
    wire src_ok      = (req_src <= `CSS_SRC_LOW_POWER_RC_OSC);

    // Register access decode
    wire wr_hi = wr && (addr == `CSS_ADDR_CTRL_HI);
    wire wr_lo = wr && (addr == `CSS_ADDR_CTRL_LO);
    wire hi_open = (hi_key == 2'd2);
    wire lo_open = (lo_key == 2'd2);
    wire lo_commit = wr_lo && lo_open;
    wire swreq_set = lo_commit && wdata[`CSS_SWREQ_BIT] && sw_enable;

    // Unlock sequencers: any other access drops the key state
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            hi_key <= 2'd0;
            lo_key <= 2'd0;
        end else begin
            if (wr_hi && hi_key == 2'd0 && wdata == `CSS_KEY_HI_A) begin
                hi_key <= 2'd1;
            end else if (wr_hi && hi_key == 2'd1 && wdata == `CSS_KEY_HI_B) begin
                hi_key <= 2'd2;
            end else if (wr || rd) begin
                hi_key <= 2'd0;
            end
            if (wr_lo && lo_key == 2'd0 && wdata == `CSS_KEY_LO_A) begin
                lo_key <= 2'd1;
            end else if (wr_lo && lo_key == 2'd1 && wdata == `CSS_KEY_LO_B) begin
                lo_key <= 2'd2;
            end else if (wr || rd) begin
                lo_key <= 2'd0;
            end
        end
    end

    // Control register fields and switch state machine
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state      <= ST_IDLE;
            cur_src    <= `CSS_SRC_FRC;
            cur_valid  <= 1'b0;
            req_src    <= `CSS_SRC_FRC;
            swreq      <= 1'b0;
            lock_flag  <= 1'b0;
            fail_flag  <= 1'b0;
            force_on   <= 1'b0;
            settle_cnt <= 4'd0;
            old_src    <= `CSS_SRC_FRC;
            new_clk_d  <= 1'b0;
        end else begin
            new_clk_d <= new_clk_s;
            // Start-up source is taken after reset release, and again every cycle while switching is disabled
            if (!cur_valid || !sw_enable) begin
                cur_src   <= startup_source;
                cur_valid <= 1'b1;
            end
            if (wr_hi && hi_open && state == ST_IDLE) begin
                req_src <= wdata[`CSS_REQ_MSB-8:`CSS_REQ_LSB-8];
            end
            if (lo_commit) begin
                force_on <= wdata[`CSS_FORCE_BIT];
            end
            if (!sw_enable) begin
                swreq <= 1'b0;
            end else if (swreq_set && state == ST_IDLE) begin
                swreq <= 1'b1;
            end
            if (lock_s && is_pll_req) begin
                lock_flag <= 1'b1;
            end
            case (state)
                ST_IDLE: begin
                    if (swreq_set) begin
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (req_src == cur_src) begin
                        swreq <= 1'b0;
                        state <= ST_IDLE;
                    end else if (pll_cross || !src_ok) begin
                        state <= ST_IDLE;
                    end else begin
                        lock_flag <= 1'b0;
                        fail_flag <= 1'b0;
                        state     <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Request stays set on a stall so software can see the lock cause
                    if (ready_s[req_src] && (!is_xtal_req || ost_s) &&
                        (!is_pll_req || lock_s)) begin
                        settle_cnt <= 4'd0;
                        state      <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (new_clk_rise) begin
                        if (settle_cnt == `CSS_SETTLE_CYCLES - 4'd1) begin
                            state <= ST_SWAP;
                        end else begin
                            settle_cnt <= settle_cnt + 4'd1;
                        end
                    end
                end
                ST_SWAP: begin
                    old_src <= cur_src;
                    cur_src <= req_src;
                    state   <= ST_HANDOFF;
                end
                ST_HANDOFF: begin
                    if (sys_clk_sel == cur_src) begin
                        swreq <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // System clock select moves in handoff only while both clocks are low; with switching disabled it follows the current source at once
    wire old_low = ~osc_clk[sys_clk_sel];
    wire new_low = ~new_clk_s;
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sys_clk_sel <= `CSS_SRC_FRC;
        end else if (!cur_valid) begin
            sys_clk_sel <= `CSS_SRC_FRC;
        end else if (state == ST_HANDOFF && old_low && new_low) begin
            sys_clk_sel <= cur_src;
        end else if (state == ST_IDLE && sys_clk_sel != cur_src && !sw_enable) begin
            sys_clk_sel <= cur_src;
        end
    end

    // Oscillator enables; secondary keep-alive terms
    wire sec_wanted = (sec_user_req ||
                       (force_on && !secondary_ext_mode)) &&
                      secondary_pin_select;
    wire switching  = (state != ST_IDLE) && (state != ST_CHECK);
    integer k;
    always @* begin
        for (k = 0; k < 6; k = k + 1) begin
            osc_enable[k] = (k == sys_clk_sel) || (k == cur_src) ||
                            (switching && k == req_src);
        end
        // Old source drops once sys_clk_sel leaves it at handoff, except for kept users
        osc_enable[`CSS_SRC_LOW_POWER_RC_OSC] = osc_enable[`CSS_SRC_LOW_POWER_RC_OSC] ||
                                    watchdog_en || fail_safe_monitor_en;
        osc_enable[`CSS_SRC_SEC]  = osc_enable[`CSS_SRC_SEC] || sec_wanted;
        osc_enable[`CSS_SRC_FRC]  = osc_enable[`CSS_SRC_FRC] ||
                                    osc_enable[`CSS_SRC_FAST_RC_WITH_PLL];
    end

    assign sec_driver_en    = secondary_pin_select && !secondary_ext_mode &&
                              osc_enable[`CSS_SRC_SEC];
    assign sec_pins_digital = !secondary_pin_select;
    assign sec_user_clk     = secondary_ext_mode ? ext_clk_s
                                                 : osc_clk[`CSS_SRC_SEC];
    assign switch_busy      = (state != ST_IDLE);
    assign core_stall       = 1'b0;

    // Read data one cycle after the strobe
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `CSS_ADDR_CTRL_LO, `CSS_ADDR_CTRL_HI:
                    rdata <= {1'b0, cur_src, 1'b0, req_src, 2'b00,
                              lock_flag, 1'b0, fail_flag, 1'b0,
                              force_on & ~secondary_ext_mode, swreq};
                `CSS_ADDR_STATUS:
                    rdata <= {10'h000, sys_clk_sel, state};
                default:
                    rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule // css_sequencer

/* File: common/css_consts.vh */
// Constants for the clock switch sequencer
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
`define CSS_ADDR_CTRL_LO    4'h0
`define CSS_ADDR_CTRL_HI    4'h1
`define CSS_ADDR_STATUS     4'h2
`define CSS_KEY_HI_A        8'h78
`define CSS_KEY_HI_B        8'h9A
`define CSS_KEY_LO_A        8'h46
`define CSS_KEY_LO_B        8'h57
`define CSS_CUR_MSB         14
`define CSS_CUR_LSB         12
`define CSS_REQ_MSB         10
`define CSS_REQ_LSB         8
`define CSS_LOCK_BIT        5
`define CSS_FAIL_BIT        3
`define CSS_FORCE_BIT       1
`define CSS_SWREQ_BIT       0
`define CSS_SRC_FRC         3'h0
`define CSS_SRC_FAST_RC_WITH_PLL      3'h1
`define CSS_SRC_PRI         3'h2
`define CSS_SRC_PRIPLL      3'h3
`define CSS_SRC_SEC         3'h4
`define CSS_SRC_LOW_POWER_RC_OSC        3'h5
`define CSS_SETTLE_CYCLES   4'd10
`define CSS_SYNC_DEPTH      3
`endif

/* File: logic/css_sync.v */
// Three-stage synchroniser, change accepted when stages two and three agree
module css_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             ref_clk,
    input  wire             rstn,
    // Data
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);
    reg [WIDTH-1:0] s1;
    reg [WIDTH-1:0] s2;
    reg [WIDTH-1:0] s3;
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge ref_clk or negedge rstn) begin
                if (!rstn) begin
                    s1[i]   <= 1'b0;
                    s2[i]   <= 1'b0;
                    s3[i]   <= 1'b0;
                    dout[i] <= 1'b0;
                end else begin
                    s1[i] <= din[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        dout[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
endmodule // css_sync

/* File: testbench/css_sequencer_sva.sv */
// Port checks for the clock switch sequencer
module css_sequencer_chk (
    // Clock, reset, register port
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic [3:0]  addr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    // Configuration
    input wire logic [1:0]  switch_config_bits,
    input wire logic        secondary_pin_select,
    input wire logic        secondary_ext_mode,
    input wire logic        watchdog_en,
    input wire logic        fail_safe_monitor_en,
    input wire logic        sec_user_req,
    // Outputs
    input wire logic [5:0]  osc_enable,
    input wire logic        sec_driver_en,
    input wire logic        sec_pins_digital,
    input wire logic [2:0]  sys_clk_sel,
    input wire logic        switch_busy,
    input wire logic        core_stall
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_never_stall: assert property (core_stall == 1'b0)
        else $error("Core stalled");
    chk_ext_driver: assert property (secondary_ext_mode |-> !sec_driver_en)
        else $error("Crystal driver on in external mode");
    chk_pins_digital: assert property (sec_pins_digital == !secondary_pin_select)
        else $error("Secondary pin mode wrong");
    chk_user_sec_on: assert property (sec_user_req && secondary_pin_select &&
        !secondary_ext_mode |-> ##[0:4] osc_enable[4])
        else $error("Secondary not started for user");
    chk_low_power_rc_osc_kept: assert property (watchdog_en || fail_safe_monitor_en |-> osc_enable[5])
        else $error("Low-power RC dropped");
    chk_sel_in_switch: assert property ($changed(sys_clk_sel) && $past(rstn) &&
        $past(switch_config_bits) == 2'b00 |-> $past(switch_busy))
        else $error("System clock moved outside a switch");
    chk_settle_wait: assert property ($rose(switch_busy) |-> ##1 $stable(sys_clk_sel) [*8])
        else $error("System clock moved before settling");
    chk_disabled_req: assert property (rd && addr < 4'h2 && switch_config_bits != 2'b00 &&
        $past(switch_config_bits) != 2'b00 |=> rdata[0] == 1'b0)
        else $error("Request bit set while switching disabled");

    cover property ($rose(switch_busy));
    cover property ($changed(sys_clk_sel));
    cover property (sec_user_req && osc_enable[4]);
endmodule // css_sequencer_chk

bind css_sequencer css_sequencer_chk u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .rd(rd), .rdata(rdata),
    .switch_config_bits(switch_config_bits), .secondary_pin_select(secondary_pin_select),
    .secondary_ext_mode(secondary_ext_mode), .watchdog_en(watchdog_en),
    .fail_safe_monitor_en(fail_safe_monitor_en), .sec_user_req(sec_user_req),
    .osc_enable(osc_enable), .sec_driver_en(sec_driver_en), .sec_pins_digital(sec_pins_digital),
    .sys_clk_sel(sys_clk_sel), .switch_busy(switch_busy), .core_stall(core_stall)
);

/* File: testbench/css_osc_model.sv */
// Behavioural oscillator bank facing the sequencer
module css_osc_model #(
    parameter int READY_NS = 200
) (
    // Controls
    input  wire logic [5:0] osc_enable,
    // Status and clocks
    output wire logic [5:0] osc_ready,
    output wire logic       pll_locked,
    output wire logic       startup_timer_done,
    output var  logic [5:0] osc_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    for (genvar i = 0; i < 6; i++) begin : g_osc
        // A disabled source stands still low, never frozen mid-level
        // Half periods above two sampling periods so the synchroniser sees every level
        always #(17 + 2 * i) osc_clk[i] = (osc_enable[i] === 1'b1) ? (osc_clk[i] !== 1'b1)
                                                                   : 1'b0;
        assign #(READY_NS) osc_ready[i] = osc_enable[i];
    end
    // Lock and start-up timer come later than ready so the waits are seen
    assign #(2 * READY_NS) pll_locked = osc_enable[1] | osc_enable[3];
    assign #(READY_NS + 50) startup_timer_done = osc_enable[2] | osc_enable[3];
endmodule // css_osc_model

/* File: testbench/css_sequencer_bench.sv */
// Self-checking bench for the clock switch sequencer
`include "css_consts.vh"
module css_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk, rstn, wr, rd, pll_locked, startup_timer_done, ext_low_freq_clk_pin;
    logic [3:0]  addr;
    logic [7:0]  wdata;
    logic [15:0] rdata, rv;
    logic [1:0]  switch_config_bits;
    logic [2:0]  startup_source, sys_clk_sel;
    logic        secondary_pin_select, secondary_ext_mode, watchdog_en, fail_safe_monitor_en;
    logic        sec_user_req, sec_driver_en, sec_pins_digital, sec_user_clk, switch_busy, core_stall;
    logic [5:0]  osc_ready, osc_clk, osc_enable;
    int          n_mismatch = 0;
    int          n_compared = 0;

    css_sequencer dut (
        .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .switch_config_bits(switch_config_bits), .startup_source(startup_source),
        .secondary_pin_select(secondary_pin_select), .secondary_ext_mode(secondary_ext_mode),
        .watchdog_en(watchdog_en), .fail_safe_monitor_en(fail_safe_monitor_en),
        .sec_user_req(sec_user_req), .osc_ready(osc_ready), .pll_locked(pll_locked),
        .startup_timer_done(startup_timer_done), .osc_clk(osc_clk),
        .ext_low_freq_clk_pin(ext_low_freq_clk_pin), .osc_enable(osc_enable),
        .sec_driver_en(sec_driver_en), .sec_pins_digital(sec_pins_digital),
        .sec_user_clk(sec_user_clk), .sys_clk_sel(sys_clk_sel), .switch_busy(switch_busy),
        .core_stall(core_stall)
    );
    css_osc_model u_osc (
        .osc_enable(osc_enable), .osc_ready(osc_ready), .pll_locked(pll_locked),
        .startup_timer_done(startup_timer_done), .osc_clk(osc_clk)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask
    // Idle cycle after each strobe keeps one assignment per signal per time step
    task automatic wr_b(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_w(input logic [3:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 rv = rdata;
        @(posedge ref_clk);
    endtask
    // No other access may fall inside an unlock sequence
    task automatic req_sel(input logic [2:0] s);
        wr_b(`CSS_ADDR_CTRL_HI, `CSS_KEY_HI_A);
        wr_b(`CSS_ADDR_CTRL_HI, `CSS_KEY_HI_B);
        wr_b(`CSS_ADDR_CTRL_HI, {5'h0, s});
    endtask
    task automatic go(input logic [7:0] lo);
        wr_b(`CSS_ADDR_CTRL_LO, `CSS_KEY_LO_A);
        wr_b(`CSS_ADDR_CTRL_LO, `CSS_KEY_LO_B);
        wr_b(`CSS_ADDR_CTRL_LO, lo);
    endtask
    task automatic wait_idle;
        for (int k = 0; k < 3000 && switch_busy !== 1'b0; k++) @(posedge ref_clk);
        cmp({15'h0, switch_busy}, 16'h0000, "switch hung");
    endtask
    task automatic print_verdict;
        $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        print_verdict();
    end

    initial begin
        rstn = 1'b0;
        {wr, rd, sec_user_req, secondary_ext_mode, fail_safe_monitor_en} = '0;
        {addr, wdata, switch_config_bits, ext_low_freq_clk_pin} = '0;
        startup_source = `CSS_SRC_FRC;
        secondary_pin_select = 1'b1;
        watchdog_en = 1'b1;
        repeat (10) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({13'h0, rv[14:12]}, 16'h0000, "current after reset");
        req_sel(`CSS_SRC_PRI);
        rd_w(`CSS_ADDR_CTRL_HI);
        cmp({13'h0, rv[10:8]}, 16'h0002, "requested field");
        go(8'h01);
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({13'h0, rv[5], rv[3], rv[0]}, 16'h0001, "flags on request");
        wait_idle();
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({9'h0, rv[14:12], 3'h0, rv[0]}, 16'h0020, "switch done");
        rd_w(`CSS_ADDR_STATUS);
        cmp({13'h0, rv[5:3]}, 16'h0002, "system clock moved");
        cmp({10'h0, osc_enable}, 16'h0024, "old source off");
        // Read between the keys must break the unlock
        wr_b(`CSS_ADDR_CTRL_HI, `CSS_KEY_HI_A);
        rd_w(`CSS_ADDR_STATUS);
        wr_b(`CSS_ADDR_CTRL_HI, `CSS_KEY_HI_B);
        wr_b(`CSS_ADDR_CTRL_HI, 8'h05);
        rd_w(`CSS_ADDR_CTRL_HI);
        cmp({13'h0, rv[10:8]}, 16'h0002, "stale selection ignored");
        go(8'h01);
        repeat (6) @(posedge ref_clk);
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({9'h0, rv[14:12], 3'h0, rv[0]}, 16'h0020, "redundant request");
        req_sel(`CSS_SRC_PRIPLL);
        go(8'h01);
        wait_idle();
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({9'h0, rv[14:12], 1'b0, rv[5], 1'b0, rv[0]}, 16'h0034, "PLL switch");
        go(8'h02);
        repeat (5) @(posedge ref_clk);
        cmp({15'h0, osc_enable[4]}, 16'h0001, "forced secondary");
        secondary_ext_mode <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({14'h0, sec_driver_en, rv[1]}, 16'h0000, "external mode");
        for (int i = 0; i < 2; i++) begin
            ext_low_freq_clk_pin <= i[0];
            repeat (6) @(posedge ref_clk);
            cmp({15'h0, sec_user_clk}, {15'h0, i[0]}, "external clock");
        end
        secondary_ext_mode <= 1'b0;
        go(8'h00);
        sec_user_req <= 1'b1;
        repeat (5) @(posedge ref_clk);
        cmp({15'h0, osc_enable[4]}, 16'h0001, "user start");
        // Digital pins take the secondary oscillator out of use
        secondary_pin_select <= 1'b0;
        repeat (5) @(posedge ref_clk);
        cmp({14'h0, osc_enable[4], sec_pins_digital}, 16'h0001, "pins digital");
        req_sel(`CSS_SRC_FAST_RC_WITH_PLL);
        go(8'h01);
        repeat (20) @(posedge ref_clk);
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({9'h0, rv[14:12], 3'h0, rv[0]}, 16'h0031, "PLL cross");
        switch_config_bits <= 2'b10;
        startup_source <= `CSS_SRC_LOW_POWER_RC_OSC;
        repeat (6) @(posedge ref_clk);
        rd_w(`CSS_ADDR_CTRL_LO);
        cmp({9'h0, rv[14:12], 3'h0, rv[0]}, 16'h0050, "disabled");
        print_verdict();
    end
endmodule // css_sequencer_bench
